// ### verilog/ided_top.sv
// ide address decode, bit 7 steering and high byte enable
`timescale 1ns/10ps
`default_nettype none
module ided_top (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [9:0] host_addr,
  input  wire logic       host_aen,
  input  wire logic       host_rd_n,
  input  wire logic       host_wr_n,
  input  wire logic       host_d7_in,
  output logic            host_d7_out,
  output logic            host_d7_oe,
  input  wire logic       drv_d7_in,
  output logic            drv_d7_out,
  output logic            drv_d7_oe,
  input  wire logic       iocs16_n,
  input  wire logic       shared_pin,
  input  wire logic       ide_enable,
  input  wire logic       base_addr_strap_1,
  input  wire logic       dma_ack_mode,
  output logic            cs0_n,
  output logic            cs1_n,
  output logic            hi_byte_en_n,
  output logic            ide_dma_ack_n,
  output logic            drive_type,
  output logic            density_select_high
);
  // ==========================================================
  // input filtering
  logic [ided_pkg::IN_W-1:0] raw;
  logic [ided_pkg::IN_W-1:0] f;

  assign raw = {drv_d7_in, host_d7_in, dma_ack_mode, base_addr_strap_1, ide_enable,
                shared_pin, iocs16_n, host_wr_n, host_rd_n, host_aen, host_addr};

  ided_sync #(
    .W    (ided_pkg::IN_W),
    .INIT (ided_pkg::IN_INIT)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (raw),
    .q       (f)
  );

  // ==========================================================
  // address decode
  logic [9:0] a;
  logic       io_cyc;
  logic       en;
  logic       sec;
  logic       pri_cmd;
  logic       sec_cmd;
  logic       hit_cs0;
  logic       hit_cs1;
  logic       pass_d7;
  logic       float_d7;

  assign a       = f[ided_pkg::ADDR_W-1:0];
  assign en      = f[ided_pkg::B_IDE_EN];
  assign sec     = f[ided_pkg::B_SECONDARY];
  assign io_cyc  = !f[ided_pkg::B_AEN] && (!f[ided_pkg::B_RD_N] || !f[ided_pkg::B_WR_N]);
  assign pri_cmd = (a & ided_pkg::CMD_MASK) == ided_pkg::PRI_CMD;
  assign sec_cmd = (a & ided_pkg::CMD_MASK) == ided_pkg::SEC_CMD;

  // cs0 command window of the strapped base
  // primary or secondary base decode, chosen by strap
  assign hit_cs0 = (!sec && pri_cmd) || (sec && sec_cmd);
  assign hit_cs1 = (!sec && (a == ided_pkg::PRI_CTL || a == ided_pkg::PRI_ADR)) ||
                   (sec && (a == ided_pkg::SEC_CTL || a == ided_pkg::SEC_ADR));
  assign pass_d7 = pri_cmd || sec_cmd || a == ided_pkg::PRI_CTL || a == ided_pkg::SEC_CTL;
  assign float_d7 = a == ided_pkg::PRI_ADR || a == ided_pkg::SEC_ADR;

  // ==========================================================
  // output registers
  logic next_cs0_n;
  logic next_cs1_n;
  logic next_hi_n;
  logic next_drv_d7_out;
  logic next_drv_d7_oe;
  logic next_host_d7_out;
  logic next_host_d7_oe;
  logic next_dack_n;
  logic next_drive_type;
  logic next_dens_high;

  always_comb begin
    next_cs0_n       = !(en && io_cyc && hit_cs0);
    next_cs1_n       = !(en && io_cyc && hit_cs1);
    next_hi_n        = !(en && io_cyc && hit_cs0 && !f[ided_pkg::B_IOCS16_N]);
    next_drv_d7_out  = f[ided_pkg::B_HOST_D7];
    next_host_d7_out = f[ided_pkg::B_DRV_D7];
    next_drv_d7_oe   = 1'b0;
    next_host_d7_oe  = 1'b0;
    if (en && io_cyc && pass_d7 && !float_d7) begin
      next_drv_d7_oe  = !f[ided_pkg::B_WR_N];
      next_host_d7_oe = !f[ided_pkg::B_RD_N];
    end
    if (f[ided_pkg::B_DMA_MODE]) begin
      next_dack_n     = f[ided_pkg::B_SHARED];
      next_drive_type = 1'b1;
      next_dens_high  = 1'b1;
    end else begin
      next_dack_n     = 1'b1;
      next_drive_type = f[ided_pkg::B_SHARED];
      next_dens_high  = f[ided_pkg::B_SHARED];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs0_n               <= 1'b1;
      cs1_n               <= 1'b1;
      hi_byte_en_n        <= 1'b1;
      drv_d7_out          <= 1'b0;
      drv_d7_oe           <= 1'b0;
      host_d7_out         <= 1'b0;
      host_d7_oe          <= 1'b0;
      ide_dma_ack_n       <= 1'b1;
      drive_type          <= 1'b1;
      density_select_high <= 1'b1;
    end else begin
      cs0_n               <= next_cs0_n;
      cs1_n               <= next_cs1_n;
      hi_byte_en_n        <= next_hi_n;
      drv_d7_out          <= next_drv_d7_out;
      drv_d7_oe           <= next_drv_d7_oe;
      host_d7_out         <= next_host_d7_out;
      host_d7_oe          <= next_host_d7_oe;
      ide_dma_ack_n       <= next_dack_n;
      drive_type          <= next_drive_type;
      density_select_high <= next_dens_high;
    end
  end

  // ==========================================================
  // checks
  property p_cs0_primary;
    @(posedge clk) disable iff (!reset_n)
      (en && !sec && io_cyc && a == 10'h1F7) |=> !cs0_n;
  endproperty
  a_cs0_primary: assert property (p_cs0_primary) else $error("cs0 missing for primary 1F7");

  property p_cs1_secondary;
    @(posedge clk) disable iff (!reset_n)
      (en && sec && io_cyc && (a == ided_pkg::SEC_CTL || a == ided_pkg::SEC_ADR)) |=> !cs1_n;
  endproperty
  a_cs1_secondary: assert property (p_cs1_secondary) else $error("cs1 missing for secondary");

  property p_disable_cs0_hi;
    @(posedge clk) disable iff (!reset_n)
      (!en)[*2] |=> (cs0_n && hi_byte_en_n);
  endproperty
  a_disable_cs0_hi: assert property (p_disable_cs0_hi) else $error("cs0 or hi byte active while disabled");

  property p_disable_cs1;
    @(posedge clk) disable iff (!reset_n)
      !cs1_n |-> $past(en);
  endproperty
  a_disable_cs1: assert property (p_disable_cs1) else $error("cs1 active while disabled");

  property p_pass_d7;
    @(posedge clk) disable iff (!reset_n)
      (en && io_cyc && !f[ided_pkg::B_WR_N] && a == ided_pkg::PRI_CTL) |=>
        (drv_d7_oe && drv_d7_out == $past(f[ided_pkg::B_HOST_D7]));
  endproperty
  a_pass_d7: assert property (p_pass_d7) else $error("bit 7 not passed on 3F6 write");

  property p_float_d7;
    @(posedge clk) disable iff (!reset_n)
      (io_cyc && (a == ided_pkg::PRI_ADR || a == ided_pkg::SEC_ADR)) |=> (!drv_d7_oe && !host_d7_oe);
  endproperty
  a_float_d7: assert property (p_float_d7) else $error("bit 7 driven at 3F7 or 377");

  property p_hi_byte;
    @(posedge clk) disable iff (!reset_n)
      !hi_byte_en_n |-> ($past(!f[ided_pkg::B_IOCS16_N]) && !cs0_n);
  endproperty
  a_hi_byte: assert property (p_hi_byte) else $error("hi byte without iocs16 or cs0");

  property p_shared_mode;
    @(posedge clk) disable iff (!reset_n)
      $past(f[ided_pkg::B_DMA_MODE]) |-> (density_select_high && drive_type &&
                                          ide_dma_ack_n == $past(f[ided_pkg::B_SHARED]));
  endproperty
  a_shared_mode: assert property (p_shared_mode) else $error("shared pin role wrong in dma mode");

  property p_outside_idle;
    @(posedge clk) disable iff (!reset_n)
      (!hit_cs0 && !hit_cs1) |=> (cs0_n && cs1_n);
  endproperty
  a_outside_idle: assert property (p_outside_idle) else $error("chip select outside ranges");
endmodule
`default_nettype wire

// ### verilog/ided_pkg.sv
// constants shared by the ide decode block
package ided_pkg;
  localparam int          ADDR_W      = 10;
  localparam logic [9:0]  PRI_CMD     = 10'h1F0;
  localparam logic [9:0]  SEC_CMD     = 10'h170;
  localparam logic [9:0]  PRI_CTL     = 10'h3F6;
  localparam logic [9:0]  PRI_ADR     = 10'h3F7;
  localparam logic [9:0]  SEC_CTL     = 10'h376;
  localparam logic [9:0]  SEC_ADR     = 10'h377;
  localparam logic [9:0]  CMD_MASK    = 10'h3F8;
  // filtered input vector layout
  localparam int          IN_W        = 20;
  localparam int          B_AEN       = 10;
  localparam int          B_RD_N      = 11;
  localparam int          B_WR_N      = 12;
  localparam int          B_IOCS16_N  = 13;
  localparam int          B_SHARED    = 14;
  localparam int          B_IDE_EN    = 15;
  localparam int          B_SECONDARY = 16;
  localparam int          B_DMA_MODE  = 17;
  localparam int          B_HOST_D7   = 18;
  localparam int          B_DRV_D7    = 19;
  // strobes, aen, iocs16 and shared pin idle high
  localparam logic [19:0] IN_INIT     = 20'h07C00;
endpackage

// ### verilog/ided_sync.sv
// three stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module ided_sync #(
  parameter int                  W    = 1,
  parameter logic [W-1:0]        INIT = '0
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [W-1:0]      d,
  output logic      [W-1:0]      q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // accept a change once stages two and three agree
      always_comb begin
        next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q  <= INIT;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q  <= next_q;
    end
  end
endmodule
`default_nettype wire

// ### bench/ided_drive_model.sv
// drive side model: 16 bit answer and read bit 7
`timescale 1ns/10ps
`default_nettype none
module ided_drive_model (
  input  wire logic clk,
  input  wire logic cs0_n,
  input  wire logic cs1_n,
  input  wire logic host_rd_n,
  input  wire logic wide,
  input  wire logic rd_bit,
  output logic      iocs16_n,
  output logic      drv_d7_in
);
  logic tog = 1'b0;
  always @(posedge clk) begin
    tog <= !tog;
  end
  // 16 bit answer only while cs0 is selected
  assign iocs16_n = !(wide && !cs0_n);
  // released data line toggles every cycle
  assign drv_d7_in = (!host_rd_n && !(cs0_n && cs1_n)) ? rd_bit : tog;
endmodule
`default_nettype wire

// ### bench/tb.sv
// random and corner testbench for the ide decode block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [9:0] host_addr = 10'h000;
  logic       host_aen = 1'b0, host_rd_n = 1'b1, host_wr_n = 1'b1, host_d7_in = 1'b0;
  logic       shared_pin = 1'b1, ide_enable = 1'b0, base_addr_strap_1 = 1'b0, dma_ack_mode = 1'b0;
  logic       wide = 1'b0, rd_bit = 1'b0;
  logic       iocs16_n, drv_d7_in, host_d7_out, host_d7_oe, drv_d7_out, drv_d7_oe;
  logic       cs0_n, cs1_n, hi_byte_en_n, ide_dma_ack_n, drive_type, density_select_high;
  int         mismatches = 0;
  int         samples_checked = 0;
  logic [9:0] picks [8] = '{10'h1F0, 10'h1F7, 10'h170, 10'h177, 10'h3F6, 10'h3F7, 10'h376, 10'h377};

  ided_top uut (.clk, .reset_n, .host_addr, .host_aen, .host_rd_n, .host_wr_n, .host_d7_in, .host_d7_out,
    .host_d7_oe, .drv_d7_in, .drv_d7_out, .drv_d7_oe, .iocs16_n, .shared_pin, .ide_enable,
    .base_addr_strap_1, .dma_ack_mode, .cs0_n, .cs1_n, .hi_byte_en_n, .ide_dma_ack_n, .drive_type,
    .density_select_high);
  ided_drive_model drive (.clk, .cs0_n, .cs1_n, .host_rd_n, .wide, .rd_bit, .iocs16_n, .drv_d7_in);

  always #2.5 clk = !clk;

  // ==========================================
  // checking helpers
  task automatic chk(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  function automatic logic in_cmd(input logic [9:0] a, input logic [9:0] base);
    return (a & ided_pkg::CMD_MASK) == base;
  endfunction

  task automatic run_case(input logic [9:0] a, input logic aen, input logic rd, input logic en,
                          input logic strap);
    logic c0, c1, fl, anyr, pass;
    {host_addr, host_aen, host_rd_n, host_wr_n, ide_enable, base_addr_strap_1} = {a, aen, !rd, rd, en, strap};
    {dma_ack_mode, shared_pin, wide, rd_bit, host_d7_in} = 5'($urandom);
    repeat (10) @(negedge clk);
    c0 = en && !aen && in_cmd(a, strap ? ided_pkg::SEC_CMD : ided_pkg::PRI_CMD);
    c1 = en && !aen && (a == (strap ? ided_pkg::SEC_CTL : ided_pkg::PRI_CTL) ||
                        a == (strap ? ided_pkg::SEC_ADR : ided_pkg::PRI_ADR));
    fl = a == ided_pkg::PRI_ADR || a == ided_pkg::SEC_ADR;
    anyr = in_cmd(a, ided_pkg::PRI_CMD) || in_cmd(a, ided_pkg::SEC_CMD) || fl ||
           a == ided_pkg::PRI_CTL || a == ided_pkg::SEC_CTL;
    pass = en && !aen && anyr && !fl;
    chk("cs0_n", !c0, cs0_n);
    chk("cs1_n", !c1, cs1_n);
    chk("hi_byte_en_n", !(c0 && wide), hi_byte_en_n);
    chk("host_d7_oe", pass && rd, host_d7_oe);
    chk("drv_d7_oe", pass && !rd, drv_d7_oe);
    // drive answers read data only while one of its selects is active
    if (pass && rd && (c0 || c1)) chk("host_d7_out", rd_bit, host_d7_out);
    if (pass && !rd) chk("drv_d7_out", host_d7_in, drv_d7_out);
    chk("ide_dma_ack_n", dma_ack_mode ? shared_pin : 1'b1, ide_dma_ack_n);
    chk("drive_type", dma_ack_mode ? 1'b1 : shared_pin, drive_type);
    chk("density_select_high", dma_ack_mode ? 1'b1 : shared_pin, density_select_high);
    {host_rd_n, host_wr_n} = 2'b11;
    repeat (6) @(negedge clk);
  endtask

  task automatic finish_test;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial begin
    logic [9:0] a;
    void'($urandom(32'h73901B29));
    repeat (3) @(negedge clk);
    chk("cs0_n", 1'b1, cs0_n);
    chk("cs1_n", 1'b1, cs1_n);
    reset_n = 1'b1;
    // every listed address, both straps, then disabled and aen cycles
    for (int i = 0; i < 64; i++) begin
      run_case(picks[i % 8], i[5] && i[4], i[3], !(i[5] && !i[4]), i[4]);
    end
    for (int i = 0; i < 150; i++) begin
      a = $urandom_range(1) ? picks[$urandom_range(7)] : 10'($urandom);
      run_case(a, $urandom_range(7) == 0, 1'($urandom), $urandom_range(7) != 0, 1'($urandom));
    end
    finish_test();
  end

  initial begin
    #40000;
    mismatches++;
    finish_test();
  end
endmodule
`default_nettype wire
